// *** rtl/spb_bridge_end.sv ***
`timescale 1ns/1ps
`include "spb_map.svh"
module spb_bridge_end (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // secondary bus
  spb_sec_if.dev SEC_BUS,
  // internal grant, active low
  input wire logic SEC_GNT_N_IN,
  // request side
  input wire logic REQ_VALID_IN,
  input wire logic [`SPB_CBE_W-1:0] REQ_CMD_IN,
  input wire logic [`SPB_AD_W-1:0] REQ_ADDR_IN,
  input wire logic [`SPB_AD_W-1:0] REQ_WDATA_IN,
  input wire logic [`SPB_CBE_W-1:0] REQ_BE_IN,
  // answer side
  output logic REQ_BUSY_OUT,
  output logic DONE_OUT,
  output logic ABORT_OUT,
  output logic RD_PAR_ERR_OUT,
  output logic [`SPB_AD_W-1:0] RD_DATA_OUT
);

  spb_pkg::spb_ini_state_t state_r;
  spb_pkg::spb_ini_state_t state_nxt;
  logic write_r;
  logic [`SPB_AD_W-1:0] wdata_r;
  logic [`SPB_CBE_W-1:0] be_r;
  logic [`SPB_WAIT_W-1:0] wait_cnt_r;
  logic [`SPB_AD_W-1:0] ad_r;
  logic ad_oe_n_r;
  logic [`SPB_CBE_W-1:0] cbe_r;
  logic cbe_oe_n_r;
  logic frame_n_r;
  logic frame_oe_n_r;
  logic irdy_n_r;
  logic irdy_oe_n_r;
  logic par_r;
  logic par_oe_n_r;
  logic chk_pend_r;
  logic chk_calc_r;
  logic bus_idle;
  logic park;
  logic start;
  logic xfer;
  logic timeout;
  logic finish;

  ////////////////////////////////////////////////////////////////////////////
  // bus condition terms
  assign bus_idle = SEC_BUS.frame_n && SEC_BUS.sec_initiator_ready_n;
  assign park = !SEC_GNT_N_IN && bus_idle && (state_r == spb_pkg::INI_IDLE);
  assign start = park && REQ_VALID_IN;
  // (R3) both readies qualify transfer
  assign xfer = (state_r == spb_pkg::INI_DATA) && !SEC_BUS.sec_initiator_ready_n
                && !SEC_BUS.sec_target_ready_n;
  assign timeout = (state_r == spb_pkg::INI_DATA) && !xfer
                   && (wait_cnt_r == `SPB_WAIT_MAX);
  assign finish = xfer || timeout;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      spb_pkg::INI_IDLE: if (start) state_nxt = spb_pkg::INI_ADDR;
      spb_pkg::INI_ADDR: state_nxt = spb_pkg::INI_DATA;
      spb_pkg::INI_DATA: if (finish) state_nxt = spb_pkg::INI_TURN;
      spb_pkg::INI_TURN: state_nxt = spb_pkg::INI_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      state_r <= spb_pkg::INI_IDLE;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      write_r <= 1'b0;
      wdata_r <= `SPB_AD_RST;
      be_r <= `SPB_CBE_RST;
    end
    else if (start)
    begin
      write_r <= REQ_CMD_IN[`SPB_CMD_WR_BIT];
      wdata_r <= REQ_WDATA_IN;
      be_r <= REQ_BE_IN;
    end
  end

  // target ready wait counter
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      wait_cnt_r <= `SPB_WAIT_RST;
    else if (state_r != spb_pkg::INI_DATA)
      wait_cnt_r <= `SPB_WAIT_RST;
    else if (!finish)
      wait_cnt_r <= wait_cnt_r + `SPB_WAIT_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // address/data lines
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      ad_r <= `SPB_AD_RST;
      ad_oe_n_r <= 1'b1;
    end
    // (R1) address with first frame clock
    else if (start)
    begin
      ad_r <= REQ_ADDR_IN;
      ad_oe_n_r <= 1'b0;
    end
    // (R2) write data held stable
    else if (state_r == spb_pkg::INI_ADDR)
    begin
      ad_r <= wdata_r;
      ad_oe_n_r <= !write_r;
    end
    else if (state_r == spb_pkg::INI_DATA)
    begin
      if (finish)
        ad_oe_n_r <= 1'b1;
    end
    // (R4) park address/data when granted
    else if (park)
    begin
      ad_r <= `SPB_PARK_AD;
      ad_oe_n_r <= 1'b0;
    end
    else
      ad_oe_n_r <= 1'b1;
  end

  // command/byte-enable lines
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      cbe_r <= `SPB_CBE_RST;
      cbe_oe_n_r <= 1'b1;
    end
    // (R5) command in address phase
    else if (start)
    begin
      cbe_r <= REQ_CMD_IN;
      cbe_oe_n_r <= 1'b0;
    end
    // (R6) byte enables in data phase
    else if (state_r == spb_pkg::INI_ADDR)
      cbe_r <= be_r;
    else if (state_r == spb_pkg::INI_DATA)
    begin
      if (finish)
        cbe_oe_n_r <= 1'b1;
    end
    // (R7) park command lines when granted
    else if (park)
    begin
      cbe_r <= `SPB_PARK_CBE;
      cbe_oe_n_r <= 1'b0;
    end
    else
      cbe_oe_n_r <= 1'b1;
  end

  // frame, driven high one cycle before release
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      frame_n_r <= 1'b1;
      frame_oe_n_r <= 1'b1;
    end
    // (R8) frame starts the access
    else if (start)
    begin
      frame_n_r <= 1'b0;
      frame_oe_n_r <= 1'b0;
    end
    // (R8) single phase, so frame ends
    else if (state_r == spb_pkg::INI_ADDR)
      frame_n_r <= 1'b1;
    else if (state_r == spb_pkg::INI_DATA)
      frame_oe_n_r <= 1'b1;
  end

  // initiator ready, driven high one cycle before release
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      irdy_n_r <= 1'b1;
      irdy_oe_n_r <= 1'b1;
    end
    else if (start)
    begin
      irdy_n_r <= 1'b1;
      irdy_oe_n_r <= 1'b0;
    end
    else if (state_r == spb_pkg::INI_ADDR)
      irdy_n_r <= 1'b0;
    else if (finish)
      irdy_n_r <= 1'b1;
    else if (state_r == spb_pkg::INI_TURN)
      irdy_oe_n_r <= 1'b1;
  end

  // (R9) even parity one clock later
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      par_r <= 1'b0;
      par_oe_n_r <= 1'b1;
    end
    else
    begin
      par_r <= ^{ad_r, cbe_r};
      par_oe_n_r <= ad_oe_n_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // (R10) read data taken on transfer
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      RD_DATA_OUT <= `SPB_AD_RST;
      chk_pend_r <= 1'b0;
      chk_calc_r <= 1'b0;
    end
    else
    begin
      chk_pend_r <= xfer && !write_r;
      if (xfer && !write_r)
      begin
        RD_DATA_OUT <= SEC_BUS.ad;
        chk_calc_r <= ^{SEC_BUS.ad, SEC_BUS.sec_cmd_byte_en};
      end
    end
  end

  // (R9) read parity checked a clock later
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      RD_PAR_ERR_OUT <= 1'b0;
    else
      RD_PAR_ERR_OUT <= chk_pend_r && (chk_calc_r != SEC_BUS.sec_parity_bit);
  end

  // answer flags
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      REQ_BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      ABORT_OUT <= 1'b0;
    end
    else
    begin
      DONE_OUT <= xfer;
      ABORT_OUT <= timeout;
      if (start)
        REQ_BUSY_OUT <= 1'b1;
      else if (state_r == spb_pkg::INI_TURN)
        REQ_BUSY_OUT <= 1'b0;
    end
  end

  // pin drivers
  assign SEC_BUS.dev_ad_out = ad_r;
  assign SEC_BUS.dev_ad_oe_n = ad_oe_n_r;
  assign SEC_BUS.dev_cbe_out = cbe_r;
  assign SEC_BUS.dev_cbe_oe_n = cbe_oe_n_r;
  assign SEC_BUS.dev_frame_n_out = frame_n_r;
  assign SEC_BUS.dev_frame_oe_n = frame_oe_n_r;
  assign SEC_BUS.dev_irdy_n_out = irdy_n_r;
  assign SEC_BUS.dev_irdy_oe_n = irdy_oe_n_r;
  assign SEC_BUS.dev_par_out = par_r;
  assign SEC_BUS.dev_par_oe_n = par_oe_n_r;

endmodule : spb_bridge_end

// *** common/spb_map.svh ***
// Function
// (R1) address with first frame clock, then data
// (R2) write data stable while initiator ready asserted
// (R3) word moves only when both readies asserted
// (R4) bridge parks address/data lines when granted, idle
// (R5) initiator drives command in address phase
// (R6) initiator drives byte enables each data phase
// (R7) bridge parks command/byte-enable lines when granted, idle
// (R8) frame spans access; release marks last phase
// (R9) even parity presented one clock after phase
// (R10) read data stable while target ready asserted
`ifndef SPB_MAP_SVH
`define SPB_MAP_SVH

// bus widths
`define SPB_AD_W 32
`define SPB_CBE_W 4

// command bit that marks a write transaction
`define SPB_CMD_WR_BIT 0

// values driven while the bridge parks the bus
`define SPB_PARK_AD 32'h0000_0000
`define SPB_PARK_CBE 4'h0

// reset values
`define SPB_AD_RST 32'h0000_0000
`define SPB_CBE_RST 4'h0

// level seen on a wire that nobody drives
`define SPB_PULL_AD 32'hffff_ffff
`define SPB_PULL_CBE 4'hf

// cycles the initiator waits for target ready before giving up
`define SPB_WAIT_W 5
`define SPB_WAIT_MAX 5'h10
`define SPB_WAIT_ONE 5'h01
`define SPB_WAIT_RST 5'h00

// address step between data phases of a target burst
`define SPB_ADDR_STEP 32'h0000_0004

`endif

// *** common/spb_pkg.sv ***
package spb_pkg;

  // initiator end states
  typedef enum logic [1:0] {
    INI_IDLE = 2'b00,
    INI_ADDR = 2'b01,
    INI_DATA = 2'b10,
    INI_TURN = 2'b11
  } spb_ini_state_t;

  // target end states
  typedef enum logic [1:0] {
    TGT_IDLE = 2'b00,
    TGT_WAIT = 2'b01,
    TGT_DATA = 2'b10,
    TGT_TURN = 2'b11
  } spb_tgt_state_t;

endpackage : spb_pkg

// *** common/spb_sec_if.sv ***
`timescale 1ns/1ps
`include "spb_map.svh"
interface spb_sec_if;

  // bridge (initiator) end drivers, enables low while driving
  logic [`SPB_AD_W-1:0] dev_ad_out;
  logic dev_ad_oe_n;
  logic [`SPB_CBE_W-1:0] dev_cbe_out;
  logic dev_cbe_oe_n;
  logic dev_par_out;
  logic dev_par_oe_n;
  logic dev_frame_n_out;
  logic dev_frame_oe_n;
  logic dev_irdy_n_out;
  logic dev_irdy_oe_n;

  // target end drivers, enables low while driving
  logic [`SPB_AD_W-1:0] tgt_ad_out;
  logic tgt_ad_oe_n;
  logic tgt_par_out;
  logic tgt_par_oe_n;
  logic tgt_trdy_n_out;
  logic tgt_trdy_oe_n;

  // resolved wire levels, undriven wires pulled high
  logic [`SPB_AD_W-1:0] ad;
  logic [`SPB_CBE_W-1:0] sec_cmd_byte_en;
  logic sec_parity_bit;
  logic frame_n;
  logic sec_initiator_ready_n;
  logic sec_target_ready_n;

  // wire resolution from the enables
  assign ad = !dev_ad_oe_n ? dev_ad_out : (!tgt_ad_oe_n ? tgt_ad_out : `SPB_PULL_AD);
  assign sec_cmd_byte_en = !dev_cbe_oe_n ? dev_cbe_out : `SPB_PULL_CBE;
  assign sec_parity_bit = !dev_par_oe_n ? dev_par_out : (!tgt_par_oe_n ? tgt_par_out : 1'b1);
  assign frame_n = !dev_frame_oe_n ? dev_frame_n_out : 1'b1;
  assign sec_initiator_ready_n = !dev_irdy_oe_n ? dev_irdy_n_out : 1'b1;
  assign sec_target_ready_n = !tgt_trdy_oe_n ? tgt_trdy_n_out : 1'b1;

  modport dev (
    output dev_ad_out, dev_ad_oe_n, dev_cbe_out, dev_cbe_oe_n,
    output dev_par_out, dev_par_oe_n, dev_frame_n_out, dev_frame_oe_n,
    output dev_irdy_n_out, dev_irdy_oe_n,
    input ad, sec_cmd_byte_en, sec_parity_bit, frame_n,
    input sec_initiator_ready_n, sec_target_ready_n
  );

  modport tgt (
    output tgt_ad_out, tgt_ad_oe_n, tgt_par_out, tgt_par_oe_n,
    output tgt_trdy_n_out, tgt_trdy_oe_n,
    input ad, sec_cmd_byte_en, sec_parity_bit, frame_n,
    input sec_initiator_ready_n, sec_target_ready_n
  );

endinterface : spb_sec_if

// *** rtl/spb_target_end.sv ***
`timescale 1ns/1ps
`include "spb_map.svh"
module spb_target_end (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // secondary bus
  spb_sec_if.tgt SEC_BUS,
  // user read data source
  input wire logic [`SPB_AD_W-1:0] RD_DATA_IN,
  // user transfer reports
  output logic WR_STROBE_OUT,
  output logic RD_STROBE_OUT,
  output logic [`SPB_AD_W-1:0] XFER_ADDR_OUT,
  output logic [`SPB_AD_W-1:0] WR_DATA_OUT,
  output logic [`SPB_CBE_W-1:0] WR_BE_OUT,
  output logic [`SPB_CBE_W-1:0] CMD_OUT
);

  spb_pkg::spb_tgt_state_t state_r;
  spb_pkg::spb_tgt_state_t state_nxt;
  logic frame_q_r;
  logic write_r;
  logic [`SPB_AD_W-1:0] addr_r;
  logic [`SPB_AD_W-1:0] ad_r;
  logic ad_oe_n_r;
  logic trdy_n_r;
  logic trdy_oe_n_r;
  logic par_r;
  logic par_oe_n_r;
  logic start;
  logic xfer;
  logic last;

  ////////////////////////////////////////////////////////////////////////////
  // (R1) address on first frame clock
  assign start = (state_r == spb_pkg::TGT_IDLE) && !SEC_BUS.frame_n && frame_q_r;
  // (R3) both readies qualify transfer
  assign xfer = (state_r == spb_pkg::TGT_DATA) && !SEC_BUS.sec_initiator_ready_n
                && !SEC_BUS.sec_target_ready_n;
  // (R8) released frame marks last
  assign last = SEC_BUS.frame_n;

  // frame level of the previous clock
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      frame_q_r <= 1'b1;
    else
      frame_q_r <= SEC_BUS.frame_n;
  end

  // next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      spb_pkg::TGT_IDLE: if (start) state_nxt = spb_pkg::TGT_WAIT;
      spb_pkg::TGT_WAIT: state_nxt = spb_pkg::TGT_DATA;
      spb_pkg::TGT_DATA: if (xfer && last) state_nxt = spb_pkg::TGT_TURN;
      spb_pkg::TGT_TURN: state_nxt = spb_pkg::TGT_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
      state_r <= spb_pkg::TGT_IDLE;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // (R5) latch command and address
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      addr_r <= `SPB_AD_RST;
      write_r <= 1'b0;
      CMD_OUT <= `SPB_CBE_RST;
    end
    else if (start)
    begin
      addr_r <= SEC_BUS.ad;
      write_r <= SEC_BUS.sec_cmd_byte_en[`SPB_CMD_WR_BIT];
      CMD_OUT <= SEC_BUS.sec_cmd_byte_en;
    end
    else if (xfer)
      addr_r <= addr_r + `SPB_ADDR_STEP;
  end

  // (R10) read data held until taken
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      ad_r <= `SPB_AD_RST;
      ad_oe_n_r <= 1'b1;
    end
    else if (state_r == spb_pkg::TGT_WAIT && !write_r)
    begin
      ad_r <= RD_DATA_IN;
      ad_oe_n_r <= 1'b0;
    end
    else if (xfer && last)
      ad_oe_n_r <= 1'b1;
    else if (xfer && !write_r)
      ad_r <= RD_DATA_IN;
  end

  // target ready, driven high one cycle before release
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      trdy_n_r <= 1'b1;
      trdy_oe_n_r <= 1'b1;
    end
    else if (start)
    begin
      trdy_n_r <= 1'b1;
      trdy_oe_n_r <= 1'b0;
    end
    else if (state_r == spb_pkg::TGT_WAIT)
      trdy_n_r <= 1'b0;
    else if (xfer && last)
      trdy_n_r <= 1'b1;
    else if (state_r == spb_pkg::TGT_TURN)
      trdy_oe_n_r <= 1'b1;
  end

  // (R9) parity one clock after data
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      par_r <= 1'b0;
      par_oe_n_r <= 1'b1;
    end
    else
    begin
      par_r <= ^{ad_r, SEC_BUS.sec_cmd_byte_en};
      par_oe_n_r <= ad_oe_n_r;
    end
  end

  // (R2) write data captured on transfer
  always_ff @(posedge MCLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      WR_STROBE_OUT <= 1'b0;
      RD_STROBE_OUT <= 1'b0;
      XFER_ADDR_OUT <= `SPB_AD_RST;
      WR_DATA_OUT <= `SPB_AD_RST;
      WR_BE_OUT <= `SPB_CBE_RST;
    end
    else
    begin
      WR_STROBE_OUT <= xfer && write_r;
      RD_STROBE_OUT <= xfer && !write_r;
      if (xfer)
      begin
        XFER_ADDR_OUT <= addr_r;
        WR_DATA_OUT <= SEC_BUS.ad;
        WR_BE_OUT <= SEC_BUS.sec_cmd_byte_en;
      end
    end
  end

  // pin drivers
  assign SEC_BUS.tgt_ad_out = ad_r;
  assign SEC_BUS.tgt_ad_oe_n = ad_oe_n_r;
  assign SEC_BUS.tgt_par_out = par_r;
  assign SEC_BUS.tgt_par_oe_n = par_oe_n_r;
  assign SEC_BUS.tgt_trdy_n_out = trdy_n_r;
  assign SEC_BUS.tgt_trdy_oe_n = trdy_oe_n_r;

endmodule : spb_target_end

// *** tb/spb_sec_asserts.sv ***
`timescale 1ns/1ps
`include "spb_map.svh"
module spb_sec_asserts (
  // clock, reset and grant
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SEC_GNT_N_IN,
  // resolved wires
  input wire logic [`SPB_AD_W-1:0] ad,
  input wire logic [`SPB_CBE_W-1:0] sec_cmd_byte_en,
  input wire logic sec_parity_bit,
  input wire logic frame_n,
  input wire logic sec_initiator_ready_n,
  input wire logic sec_target_ready_n,
  // driver enables
  input wire logic dev_ad_oe_n,
  input wire logic dev_cbe_oe_n,
  input wire logic tgt_ad_oe_n
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // transfer timing
  property p_data_follows;
    $fell(frame_n) |=> !sec_initiator_ready_n;
  endproperty
  a_data_follows: assert property (p_data_follows)
    else $error("no data phase after address phase");
  property p_wr_stable;
    (!sec_initiator_ready_n && sec_target_ready_n && !dev_ad_oe_n) |=> $stable(ad);
  endproperty
  a_wr_stable: assert property (p_wr_stable)
    else $error("write data moved while waiting for target");
  property p_xfer_bound;
    $fell(frame_n) |-> ##[1:18] (!sec_initiator_ready_n && !sec_target_ready_n);
  endproperty
  a_xfer_bound: assert property (p_xfer_bound)
    else $error("no transfer edge after address");
  property p_xfer_end;
    (!sec_initiator_ready_n && !sec_target_ready_n) |=> sec_initiator_ready_n && frame_n;
  endproperty
  a_xfer_end: assert property (p_xfer_end)
    else $error("initiator ready held after transfer");
  property p_single;
    $fell(frame_n) |=> frame_n;
  endproperty
  a_single: assert property (p_single)
    else $error("frame not released for last phase");

  ////////////////////////////////////////////////////////////////////////////////////////////
  // command, byte enables, parity
  property p_cmd_drive;
    $fell(frame_n) |-> !dev_cbe_oe_n && !dev_ad_oe_n;
  endproperty
  a_cmd_drive: assert property (p_cmd_drive)
    else $error("address phase lines not driven");
  property p_be_drive;
    !sec_initiator_ready_n |-> !dev_cbe_oe_n;
  endproperty
  a_be_drive: assert property (p_be_drive)
    else $error("byte enables not driven in data phase");
  property p_parity;
    (!dev_ad_oe_n || !tgt_ad_oe_n) |=>
      (^{$past(ad), $past(sec_cmd_byte_en), sec_parity_bit}) == 1'b0;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity not even one clock after phase");

  ////////////////////////////////////////////////////////////////////////////////////////////
  // parking
  property p_park_ad;
    (!SEC_GNT_N_IN && frame_n && sec_initiator_ready_n)[*4] |=> (!frame_n || ad == `SPB_PARK_AD);
  endproperty
  a_park_ad: assert property (p_park_ad)
    else $error("address lines not parked");
  property p_park_cbe;
    (!SEC_GNT_N_IN && frame_n && sec_initiator_ready_n)[*4] |=>
      (!frame_n || sec_cmd_byte_en == `SPB_PARK_CBE);
  endproperty
  a_park_cbe: assert property (p_park_cbe)
    else $error("command lines not parked");

  // main scenarios
  c_write: cover property (!sec_initiator_ready_n && !sec_target_ready_n && !dev_ad_oe_n);
  c_read: cover property (!sec_initiator_ready_n && !sec_target_ready_n && !tgt_ad_oe_n);
  c_park: cover property (frame_n && !dev_ad_oe_n && ad == `SPB_PARK_AD);
endmodule : spb_sec_asserts

// *** tb/secondary_pci_addr_data_port_test.sv ***
`timescale 1ns/1ps
`include "spb_map.svh"
module secondary_pci_addr_data_port_test;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic gnt_n = 1'b1;
  logic req_valid = 1'b0;
  logic [3:0] req_cmd = 4'h0;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0] req_be = 4'h0;
  logic [31:0] rd_src = 32'h0;
  logic busy, done, abort, par_err, wr_stb, rd_stb, wr_c;
  logic [31:0] rd_data, x_addr, w_data, addr_c, data_c, a_seen, d_seen;
  logic [3:0] w_be, t_cmd, cmd_c, c_seen, be_seen, be_c;
  logic prev_frame_n = 1'b1;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  spb_sec_if sec_bus ();
  spb_bridge_end u_spb_bridge_end (
    .MCLK_IN(mclk), .SYS_RST_IN(sys_rst), .SEC_BUS(sec_bus), .SEC_GNT_N_IN(gnt_n),
    .REQ_VALID_IN(req_valid), .REQ_CMD_IN(req_cmd), .REQ_ADDR_IN(req_addr),
    .REQ_WDATA_IN(req_wdata), .REQ_BE_IN(req_be), .REQ_BUSY_OUT(busy), .DONE_OUT(done),
    .ABORT_OUT(abort), .RD_PAR_ERR_OUT(par_err), .RD_DATA_OUT(rd_data));
  spb_target_end u_spb_target_end (
    .MCLK_IN(mclk), .SYS_RST_IN(sys_rst), .SEC_BUS(sec_bus), .RD_DATA_IN(rd_src),
    .WR_STROBE_OUT(wr_stb), .RD_STROBE_OUT(rd_stb), .XFER_ADDR_OUT(x_addr),
    .WR_DATA_OUT(w_data), .WR_BE_OUT(w_be), .CMD_OUT(t_cmd));
  spb_sec_asserts u_spb_sec_asserts (
    .MCLK_IN(mclk), .SYS_RST_IN(sys_rst), .SEC_GNT_N_IN(gnt_n), .ad(sec_bus.ad),
    .sec_cmd_byte_en(sec_bus.sec_cmd_byte_en), .sec_parity_bit(sec_bus.sec_parity_bit),
    .frame_n(sec_bus.frame_n), .sec_initiator_ready_n(sec_bus.sec_initiator_ready_n),
    .sec_target_ready_n(sec_bus.sec_target_ready_n), .dev_ad_oe_n(sec_bus.dev_ad_oe_n),
    .dev_cbe_oe_n(sec_bus.dev_cbe_oe_n), .tgt_ad_oe_n(sec_bus.tgt_ad_oe_n));

  // clock
  initial
  begin
    forever #10 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // wire and user-side capture, error pulses, hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    prev_frame_n <= sec_bus.frame_n;
    if (prev_frame_n === 1'b1 && sec_bus.frame_n === 1'b0)
    begin
      a_seen <= sec_bus.ad;
      c_seen <= sec_bus.sec_cmd_byte_en;
    end
    if (sec_bus.sec_initiator_ready_n === 1'b0 && sec_bus.sec_target_ready_n === 1'b0)
    begin
      d_seen <= sec_bus.ad;
      be_seen <= sec_bus.sec_cmd_byte_en;
    end
    if (wr_stb === 1'b1 || rd_stb === 1'b1)
    begin
      addr_c <= x_addr;
      data_c <= w_data;
      cmd_c <= t_cmd;
      be_c <= w_be;
      wr_c <= wr_stb;
    end
    if (!sys_rst && (abort !== 1'b0 || par_err !== 1'b0))
      chk({30'h0, abort, par_err}, 32'h0);
    if (cycles > 4000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // 0: busy high, 1: done pulse, 2: busy low; bounded
  task automatic step_until(input int what);
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (n < 40 && (what == 0 ? busy !== 1'b1 : (what == 1 ? done !== 1'b1 : busy !== 1'b0)));
  endtask : step_until

  task automatic do_req(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd);
    req_valid <= 1'b1;
    req_cmd <= cmd;
    req_addr <= addr;
    req_wdata <= wd;
    req_be <= ~cmd;
    step_until(0);
    req_valid <= 1'b0;
    step_until(1);
    chk({31'h0, done}, 32'h1);
    step_until(2);
  endtask : do_req

  ////////////////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_park();
    gnt_n <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(sec_bus.ad, `SPB_PARK_AD);
    chk({28'h0, sec_bus.sec_cmd_byte_en}, {28'h0, `SPB_PARK_CBE});
    chk({31'h0, sec_bus.sec_parity_bit}, {31'h0, ^{`SPB_PARK_AD, `SPB_PARK_CBE}});
    gnt_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk(sec_bus.ad, `SPB_PULL_AD);
  endtask : sc_park

  task automatic sc_no_grant();
    req_valid <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({31'h0, sec_bus.frame_n}, 32'h1);
    gnt_n <= 1'b0;
    do_req(4'h7, 32'h0000_2a40, 32'h1234_5678);
    chk(data_c, 32'h1234_5678);
  endtask : sc_no_grant

  // every command back to back, writes on odd codes, reads on even
  task automatic sc_all_cmds();
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [31:0] exp_d;
    for (int c = 0; c < 16; c++)
    begin
      cmd = c[3:0];
      addr = {24'h001000, cmd, 4'h0};
      exp_d = cmd[0] ? {16'ha500, 12'h000, cmd} : {16'h5a00, 12'h000, cmd};
      rd_src <= exp_d;
      do_req(cmd, addr, exp_d);
      chk(a_seen, addr);
      chk({28'h0, c_seen}, {28'h0, cmd});
      chk(d_seen, exp_d);
      chk({28'h0, be_seen}, {28'h0, ~cmd});
      chk({28'h0, cmd_c}, {28'h0, cmd});
      chk(addr_c, addr);
      chk({31'h0, wr_c}, {31'h0, cmd[0]});
      if (cmd[0])
      begin
        chk(data_c, exp_d);
        chk({28'h0, be_c}, {28'h0, ~cmd});
      end
      else
        chk(rd_data, exp_d);
    end
  endtask : sc_all_cmds

  ////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    sc_park();
    sc_no_grant();
    sc_all_cmds();
    complete_run();
  end
endmodule : secondary_pci_addr_data_port_test
